// ### rtl/mirsu_top.sv
// Interrupt flags, enables, service sequencing, wake-up and reset-state patterns.
// Assumes all inputs synchronous to pclk; presetn acts as power-on reset.
// Notes on behaviour
// - Global enable bit 7 passes all unmasked requests when set, blocks all when clear.
// - Any reset clears the global enable.
// - Return from service sets the global enable again.
// - Servicing clears global enable, pushes return address, loads vector 0004h.
// - Latency three cycles synchronous, three to four asynchronous, any instruction.
// - Flags set on their event regardless of any enable.
// - Clearing global enable drops requests due next cycle; they stay pending.
// - Edge pin rising when option bit 6 set, falling when clear.
// - Valid pin edge sets flag bit 1; its request is gated by enable bit 4.
// - Pin interrupt wakes from sleep if enabled; global enable decides branch.
// - On wake with global enable, run PC+1 first, then vector.
// - Timer wrap FFh to 00h sets flag bit 2, enable bit 5.
// - Masked port change sets flag bit 0, enable bit 3.
// - Port change during a port read at Q2 may be missed.
// - Pin flag set during Q4 to Q1, sampled every Q1.
// - Peripheral flags and enables in two register pairs, reset to zero.
// - All resets load PC 000h; watchdog and interrupt wake continue next.
// - Interrupt wake status uuu1 0uuu, watchdog wake uuu0 0uuu, power bits kept.
// - Reset status and power-control patterns per reset cause.
// - Only the return PC is saved on entry.
`timescale 1ns/1ps
`default_nettype none
`include "mirsu_cfg.svh"
module mirsu_top #(
    parameter int PA_W = 6,
    parameter int PB_W = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core events and reset causes
    input wire mirsu_pkg::mirsu_core_evt_t core_evt,
    input wire mirsu_pkg::mirsu_cause_t cause,
    // Flag sources
    input wire logic external_edge_pin,
    input wire logic [PA_W-1:0] port_a_pins,
    input wire logic [PB_W-1:0] port_b_pins,
    input wire logic timer_wrap,
    input wire logic [7:0] periph_one_set,
    input wire logic [7:0] periph_two_set,
    // Core control
    output logic service_start,
    output logic push_return,
    output logic pc_load,
    output logic [12:0] pc_value,
    output logic wake_up,
    output logic [1:0] tcy_phase
);

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    // Byte write with set-wins merge for hardware flags
    function automatic logic [7:0] merge(input logic [7:0] cur, input logic wr,
                                         input logic [7:0] wd, input logic [7:0] set);
        merge = (wr ? wd : cur) | set;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    mirsu_pkg::mirsu_phase_t phase_r;
    logic [7:0] intctl_r;
    logic [7:0] option_r;
    logic [7:0] preq1_r;
    logic [7:0] preq2_r;
    logic [7:0] pen1_r;
    logic [7:0] pen2_r;
    logic [7:0] pamask_r;
    logic [7:0] pbmask_r;
    logic [7:0] status_r;
    logic [3:0] pwrctl_r;
    logic pin_prev_r;
    logic pin_edge_r;
    logic [PA_W-1:0] pa_latch_r;
    logic [PB_W-1:0] pb_latch_r;
    logic svc_busy_r;
    logic [1:0] svc_cnt_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic service_r;
    logic pc_load_r;
    logic [12:0] pc_value_r;
    logic wake_r;
    logic [1:0] phase_out_r;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic wr_acc;
    logic is_q1;
    logic mapped;
    logic pin_edge_now;
    logic [PA_W-1:0] pa_chg;
    logic [PB_W-1:0] pb_chg;
    logic pch_set;
    logic periph_any;
    logic core_req;
    logic wake_req;
    logic any_reset;
    logic [31:0] rd_mux;

    assign wr_acc = psel && penable && pready_r && pwrite;
    assign is_q1 = (phase_r == mirsu_pkg::MIRSU_Q1);
    assign any_reset = cause.brown_out | cause.master_clear | cause.wdt_reset;

    // Edge of the selected polarity on the pin
    assign pin_edge_now = option_r[`MIRSU_B_EDGE] ? (external_edge_pin && !pin_prev_r)
                                                  : (!external_edge_pin && pin_prev_r);

    // Per-pin change against the last value the port read captured
    assign pa_chg = (port_a_pins ^ pa_latch_r) & pamask_r[PA_W-1:0];
    assign pb_chg = (port_b_pins ^ pb_latch_r) & pbmask_r[PB_W-1:0];
    assign pch_set = (|pa_chg) | (|pb_chg);

    // Request before the global gate; also the wake-up condition
    assign periph_any = intctl_r[`MIRSU_B_PERIPHERAL_IRQ_ENABLE] &&
                        (|(preq1_r & pen1_r) || |(preq2_r & pen2_r));
    assign wake_req = (intctl_r[`MIRSU_B_PINE] && intctl_r[`MIRSU_B_PINF]) ||
                      (intctl_r[`MIRSU_B_TIMER_ZERO_OVERFLOW_ENABLE] && intctl_r[`MIRSU_B_TIMER_ZERO_OVERFLOW_FLAG]) ||
                      (intctl_r[`MIRSU_B_PCHE] && intctl_r[`MIRSU_B_PCHF]) ||
                      periph_any;
    assign core_req = wake_req && intctl_r[`MIRSU_B_GIE] && !core_evt.sleeping;

    // Read multiplexer; unmapped offsets answer with an error
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b1;
        unique case (paddr)
            `MIRSU_OFS_INTCTL: rd_mux[7:0] = intctl_r;
            `MIRSU_OFS_OPTION: rd_mux[7:0] = option_r;
            `MIRSU_OFS_PREQ1: rd_mux[7:0] = preq1_r;
            `MIRSU_OFS_PREQ2: rd_mux[7:0] = preq2_r;
            `MIRSU_OFS_PEN1: rd_mux[7:0] = pen1_r;
            `MIRSU_OFS_PEN2: rd_mux[7:0] = pen2_r;
            `MIRSU_OFS_PAMASK: rd_mux[7:0] = pamask_r;
            `MIRSU_OFS_PBMASK: rd_mux[7:0] = pbmask_r;
            `MIRSU_OFS_STATUS: rd_mux[7:0] = status_r;
            `MIRSU_OFS_PWRCTL: rd_mux[3:0] = pwrctl_r;
            default: mapped = 1'b0;
        endcase
    end

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    // Ready is raised in the setup cycle so every access completes in one access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= psel && !penable;
            // Error stands only beside ready, so it never outlives the access
            pslverr_r <= psel && !penable && !mapped;
            if (psel && !penable)
                prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    // ----------------------------------------
    // Instruction cycle phases
    // ----------------------------------------
    // Four pclk per instruction cycle, Q1 first
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_r <= mirsu_pkg::MIRSU_Q1;
        else
        begin
            unique case (phase_r)
                mirsu_pkg::MIRSU_Q1: phase_r <= mirsu_pkg::MIRSU_Q2;
                mirsu_pkg::MIRSU_Q2: phase_r <= mirsu_pkg::MIRSU_Q3;
                mirsu_pkg::MIRSU_Q3: phase_r <= mirsu_pkg::MIRSU_Q4;
                mirsu_pkg::MIRSU_Q4: phase_r <= mirsu_pkg::MIRSU_Q1;
            endcase
        end
    end

    // ----------------------------------------
    // Pin edge capture
    // ----------------------------------------
    // Edges are held until the Q4-Q1 window lets the flag take them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_prev_r <= 1'b0;
            pin_edge_r <= 1'b0;
        end
        else
        begin
            pin_prev_r <= external_edge_pin;
            if (phase_r == mirsu_pkg::MIRSU_Q4 || is_q1)
                pin_edge_r <= 1'b0;
            else if (pin_edge_now)
                pin_edge_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Port change reference
    // ----------------------------------------
    // A read refreshes the reference; a change landing in that cycle is absorbed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pa_latch_r <= '0;
            pb_latch_r <= '0;
        end
        else if (core_evt.port_read)
        begin
            pa_latch_r <= port_a_pins;
            pb_latch_r <= port_b_pins;
        end
    end

    // ----------------------------------------
    // Interrupt control register
    // ----------------------------------------
    // Flags set on their events whatever the enables; set wins over a write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            intctl_r <= 8'h00;
        else
        begin
            logic [7:0] set_v;
            logic [7:0] nxt_v;
            set_v = 8'h00;
            set_v[`MIRSU_B_PINF] = (pin_edge_r || pin_edge_now) &&
                                   (phase_r == mirsu_pkg::MIRSU_Q4 || is_q1);
            set_v[`MIRSU_B_TIMER_ZERO_OVERFLOW_FLAG] = timer_wrap;
            set_v[`MIRSU_B_PCHF] = pch_set && !core_evt.port_read;
            nxt_v = merge(intctl_r, wr_acc && paddr == `MIRSU_OFS_INTCTL, pwdata[7:0], set_v);
            if (core_evt.return_from_service)
                nxt_v[`MIRSU_B_GIE] = 1'b1;
            if (core_evt.gie_clear)
                nxt_v[`MIRSU_B_GIE] = 1'b0;
            if (svc_busy_r && svc_cnt_r == 2'h0 && is_q1 && core_req)
                nxt_v[`MIRSU_B_GIE] = 1'b0;
            if (any_reset)
            begin
                nxt_v[7:1] = 7'h00;
            end
            intctl_r <= nxt_v;
        end
    end

    // ----------------------------------------
    // Peripheral requests and enables
    // ----------------------------------------
    // Unimplemented bits are held at zero by the masks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            preq1_r <= 8'h00;
            preq2_r <= 8'h00;
            pen1_r <= 8'h00;
            pen2_r <= 8'h00;
        end
        else if (any_reset)
        begin
            preq1_r <= 8'h00;
            preq2_r <= 8'h00;
            pen1_r <= 8'h00;
            pen2_r <= 8'h00;
        end
        else
        begin
            preq1_r <= merge(preq1_r, wr_acc && paddr == `MIRSU_OFS_PREQ1, pwdata[7:0],
                             periph_one_set) & `MIRSU_MASK_P1;
            preq2_r <= merge(preq2_r, wr_acc && paddr == `MIRSU_OFS_PREQ2, pwdata[7:0],
                             periph_two_set) & `MIRSU_MASK_P2;
            pen1_r <= merge(pen1_r, wr_acc && paddr == `MIRSU_OFS_PEN1, pwdata[7:0],
                            8'h00) & `MIRSU_MASK_P1;
            pen2_r <= merge(pen2_r, wr_acc && paddr == `MIRSU_OFS_PEN2, pwdata[7:0],
                            8'h00) & `MIRSU_MASK_P2;
        end
    end

    // ----------------------------------------
    // Option and change masks
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            option_r <= `MIRSU_RST_OPTION;
            pamask_r <= 8'h00;
            pbmask_r <= 8'h00;
        end
        else
        begin
            option_r <= merge(option_r, wr_acc && paddr == `MIRSU_OFS_OPTION, pwdata[7:0],
                              8'h00);
            pamask_r <= merge(pamask_r, wr_acc && paddr == `MIRSU_OFS_PAMASK, pwdata[7:0],
                              8'h00) & `MIRSU_MASK_PA;
            pbmask_r <= merge(pbmask_r, wr_acc && paddr == `MIRSU_OFS_PBMASK, pwdata[7:0],
                              8'h00) & `MIRSU_MASK_PB;
        end
    end

    // ----------------------------------------
    // Service sequencer
    // ----------------------------------------
    // A request seen at Q1 waits two more cycles, so entry lands in the third;
    // counting whole cycles keeps latency independent of instruction length
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            svc_busy_r <= 1'b0;
            svc_cnt_r <= 2'h0;
        end
        else if (any_reset || core_evt.gie_clear || !intctl_r[`MIRSU_B_GIE])
        begin
            svc_busy_r <= 1'b0;
            svc_cnt_r <= 2'h0;
        end
        else if (is_q1)
        begin
            if (!svc_busy_r && core_req)
            begin
                svc_busy_r <= 1'b1;
                svc_cnt_r <= `MIRSU_SVC_WAIT_TCY;
            end
            else if (svc_busy_r && svc_cnt_r != 2'h0)
                svc_cnt_r <= svc_cnt_r - 2'h1;
            else if (svc_busy_r)
                svc_busy_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Core control outputs
    // ----------------------------------------
    // Wake does not need the global enable; the sequencer then runs the
    // next instruction before the vector, which is why wake is not a service
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            service_r <= 1'b0;
            pc_load_r <= 1'b1;
            pc_value_r <= `MIRSU_VEC_RESET;
            wake_r <= 1'b0;
            phase_out_r <= 2'h0;
        end
        else
        begin
            phase_out_r <= phase_r;
            service_r <= svc_busy_r && svc_cnt_r == 2'h0 && is_q1 && core_req &&
                         !core_evt.gie_clear && !any_reset;
            wake_r <= core_evt.sleeping && wake_req;
            if (any_reset)
            begin
                pc_load_r <= 1'b1;
                pc_value_r <= `MIRSU_VEC_RESET;
            end
            else if (svc_busy_r && svc_cnt_r == 2'h0 && is_q1 && core_req &&
                     !core_evt.gie_clear)
            begin
                pc_load_r <= 1'b1;
                pc_value_r <= `MIRSU_VEC_IRQ;
            end
            else
                pc_load_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Status and power-control patterns
    // ----------------------------------------
    // Software owns all status bits but timeout and power-down; power control is read-only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_r <= `MIRSU_RST_STATUS;
            pwrctl_r <= `MIRSU_RST_PWRCTL;
        end
        else
        begin
            logic [7:0] st_v;
            st_v = status_r;
            if (wr_acc && paddr == `MIRSU_OFS_STATUS)
                st_v = {pwdata[7:5], status_r[4:3], pwdata[2:0]};
            if (cause.brown_out)
            begin
                st_v[7:3] = 5'h03;
                pwrctl_r <= {2'b01, pwrctl_r[1], 1'b0};
            end
            else if (cause.master_clear)
            begin
                st_v[7:5] = 3'h0;
                if (core_evt.sleeping)
                    st_v[4:3] = 2'b10;
                pwrctl_r[3] <= 1'b0;
            end
            else if (cause.wdt_reset)
            begin
                st_v[7:4] = 4'h0;
                pwrctl_r[3] <= 1'b0;
            end
            else if (cause.wdt_wake)
                st_v[4:3] = 2'b00;
            else if (core_evt.sleeping && wake_req)
                st_v[4:3] = 2'b10;
            status_r <= st_v;
        end
    end

    // ----------------------------------------
    // Port drive
    // ----------------------------------------
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign service_start = service_r;
    assign push_return = service_r;
    assign pc_load = pc_load_r;
    assign pc_value = pc_value_r;
    assign wake_up = wake_r;
    assign tcy_phase = phase_out_r;

endmodule
`default_nettype wire

// ### rtl/mirsu_cfg.svh
// Constants of the interrupt and reset-state unit: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the top module.
`ifndef MIRSU_CFG_SVH
`define MIRSU_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MIRSU_OFS_INTCTL 8'h00
`define MIRSU_OFS_OPTION 8'h04
`define MIRSU_OFS_PREQ1 8'h08
`define MIRSU_OFS_PREQ2 8'h0C
`define MIRSU_OFS_PEN1 8'h10
`define MIRSU_OFS_PEN2 8'h14
`define MIRSU_OFS_PAMASK 8'h18
`define MIRSU_OFS_PBMASK 8'h1C
`define MIRSU_OFS_STATUS 8'h20
`define MIRSU_OFS_PWRCTL 8'h24
// ----------------------------------------
// Interrupt control, option edge and status field positions
// ----------------------------------------
`define MIRSU_B_GIE 7
`define MIRSU_B_PERIPHERAL_IRQ_ENABLE 6
`define MIRSU_B_TIMER_ZERO_OVERFLOW_ENABLE 5
`define MIRSU_B_PINE 4
`define MIRSU_B_PCHE 3
`define MIRSU_B_TIMER_ZERO_OVERFLOW_FLAG 2
`define MIRSU_B_PINF 1
`define MIRSU_B_PCHF 0
`define MIRSU_B_EDGE 6
`define MIRSU_B_TO 4
`define MIRSU_B_PD 3
// ----------------------------------------
// Implemented bit masks and reset values
// ----------------------------------------
`define MIRSU_MASK_P1 8'h7F
`define MIRSU_MASK_P2 8'hF0
`define MIRSU_MASK_PA 8'h3F
`define MIRSU_MASK_PB 8'h0F
`define MIRSU_RST_OPTION 8'hFF
`define MIRSU_RST_STATUS 8'h18
`define MIRSU_RST_PWRCTL 4'h4
// ----------------------------------------
// Vectors and timing
// ----------------------------------------
`define MIRSU_VEC_RESET 13'h0000
`define MIRSU_VEC_IRQ 13'h0004
`define MIRSU_SVC_WAIT_TCY 2'h2
`endif

// ### rtl/mirsu_pkg.sv
// Types shared by the interrupt and reset-state unit.
// Assumes the constants header is on the include path.
package mirsu_pkg;
    // Instruction cycle phase, one pclk each
    typedef enum logic [1:0] {
        MIRSU_Q1 = 2'b00,
        MIRSU_Q2 = 2'b01,
        MIRSU_Q3 = 2'b10,
        MIRSU_Q4 = 2'b11
    } mirsu_phase_t;
    // Events reported by the core, one-cycle pulses except sleeping
    typedef struct packed {
        logic return_from_service;
        logic gie_clear;
        logic sleeping;
        logic port_read;
    } mirsu_core_evt_t;
    // Reset and wake causes, one-cycle pulses
    typedef struct packed {
        logic brown_out;
        logic master_clear;
        logic wdt_reset;
        logic wdt_wake;
    } mirsu_cause_t;
endpackage

// ### dv/mirsu_assertions.sv
// Checker of the unit's port timing and service behaviour.
// Assumes it is bound onto mirsu_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mirsu_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Core side
    input wire mirsu_pkg::mirsu_core_evt_t core_evt,
    input wire mirsu_pkg::mirsu_cause_t cause,
    input wire logic service_start,
    input wire logic push_return,
    input wire logic pc_load,
    input wire logic [12:0] pc_value,
    input wire logic wake_up
);
    // ----------------------------------------
    // Properties, all in the pclk domain
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_svc; service_start |-> push_return && pc_load && pc_value == 13'h0004; endproperty
    a_svc: assert property (p_svc) else $error("service entry outputs wrong");
    // Global enable is cleared on entry, so no second entry can follow soon
    property p_gap; service_start |=> !service_start [*8]; endproperty
    a_gap: assert property (p_gap) else $error("service repeated too soon");
    property p_drop; core_evt.gie_clear |=> !service_start [*8]; endproperty
    a_drop: assert property (p_drop) else $error("service after enable clear");
    property p_rst;
        (cause.brown_out || cause.master_clear || cause.wdt_reset)
            |-> ##[1:2] (pc_load && pc_value == 13'h0000);
    endproperty
    a_rst: assert property (p_rst) else $error("reset cause without pc load");
    property p_pc; pc_load |-> (pc_value == 13'h0000 || pc_value == 13'h0004); endproperty
    a_pc: assert property (p_pc) else $error("pc load with odd value");
    property p_wake; wake_up |-> $past(core_evt.sleeping); endproperty
    a_wake: assert property (p_wake) else $error("wake while awake");
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held too long");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error outside access");
    c_svc: cover property (service_start);
    c_wake: cover property (wake_up);
    c_err: cover property (pslverr);
    c_rst: cover property (cause.master_clear);
endmodule
bind mirsu_top mirsu_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .core_evt(core_evt),
    .cause(cause), .service_start(service_start), .push_return(push_return),
    .pc_load(pc_load), .pc_value(pc_value), .wake_up(wake_up));
`default_nettype wire

// ### dv/mirsu_core_model.sv
// Core-side partner: turns bench requests into the core's event pulses.
// Assumes requests are one-cycle pulses, sleep a level, all on pclk.
`timescale 1ns/1ps
`default_nettype none
module mirsu_core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench requests
    input wire logic ret_req,
    input wire logic clr_req,
    input wire logic slp_req,
    input wire logic rd_req,
    // Events to the unit
    output mirsu_pkg::mirsu_core_evt_t core_evt
);
    // Registered like a real core, so events never change at the edge that samples them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_evt <= '0;
        else
            core_evt <= {ret_req, clr_req, slp_req, rd_req};
    end
endmodule
`default_nettype wire

// ### dv/mirsu_interrupt_and_reset_state_unit_tb_top.sv
// Bench for the interrupt and reset-state unit, driving APB and flag sources.
// Assumes the core partner model and the bound checker are compiled too.
`timescale 1ns/1ps
`default_nettype none
module mirsu_interrupt_and_reset_state_unit_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin = 0;
    logic [7:0] paddr = 0, p1 = 0, p2 = 0;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic pready, pslverr, err, svc, push, pcl, wake, twrap = 0;
    logic ret = 0, clr = 0, slp = 0, rdp = 0;
    logic [5:0] pa = 0;
    logic [3:0] pb = 0, cs = 0;
    logic [12:0] pcv;
    logic [1:0] ph;
    mirsu_pkg::mirsu_core_evt_t ev;
    int miscompares = 0, num_checks = 0;
    always #2 pclk = ~pclk;
    mirsu_core_model CORE (.pclk(pclk), .presetn(presetn), .ret_req(ret), .clr_req(clr),
        .slp_req(slp), .rd_req(rdp), .core_evt(ev));
    mirsu_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_evt(ev), .cause(cs), .external_edge_pin(pin),
        .port_a_pins(pa), .port_b_pins(pb), .timer_wrap(twrap), .periph_one_set(p1),
        .periph_two_set(p2), .service_start(svc), .push_return(push), .pc_load(pcl),
        .pc_value(pcv), .wake_up(wake), .tcy_phase(ph));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until pready is sampled high; data taken at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            miscompares++;
            wrap_up();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, {24'h0, exp});
    endtask
    // Bounded look for service (0) or wake (1); limit sits above the longest latency
    task automatic wait_for(input int which, input logic exp);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < 40 && hit !== 1'b1; n++)
        begin
            @(posedge pclk);
            hit = (which == 0) ? svc : wake;
        end
        chk({31'h0, hit === 1'b1}, {31'h0, exp});
        if (exp && hit !== 1'b1)
            wrap_up();
    endtask
    task automatic pulse(input int k, input logic [3:0] v);
        @(posedge pclk);
        if (k == 0) twrap <= 1'b1; else if (k == 1) ret <= 1'b1; else if (k == 2) clr <= 1'b1;
        else if (k == 3) rdp <= 1'b1; else if (k == 4) p1 <= 8'h01; else cs <= v;
        @(posedge pclk);
        {twrap, ret, clr, rdp, p1, cs} <= '0;
        repeat (6) @(posedge pclk);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] ad[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
                               8'h24};
        logic [7:0] rv[10] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h18,
                               8'h04};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ad[i]) rd(ad[i], rv[i]);
        rd(8'h28, 8'h00);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 8'h10, 32'hFF);
        rd(8'h10, 8'h7F);
        // Phase output advances by one per pclk
        @(posedge pclk);
        rdat[1:0] = ph;
        @(posedge pclk);
        chk({30'h0, ph}, {30'h0, rdat[1:0] + 2'h1});
        $display("reset values done");
        pulse(0, 0);
        rd(8'h00, 8'h04);
        pin <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(8'h00, 8'h06);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'hBF);
        pin <= 1'b0;
        repeat (6) @(posedge pclk);
        rd(8'h00, 8'h02);
        apb(1'b1, 8'h00, 32'h0);
        pin <= 1'b1;
        repeat (6) @(posedge pclk);
        rd(8'h00, 8'h00);
        apb(1'b1, 8'h18, 32'h01);
        pulse(3, 0);
        pa <= 6'h01;
        pb <= 4'h1;
        repeat (6) @(posedge pclk);
        rd(8'h00, 8'h01);
        // A port read ends the mismatch, else the flag sets again at once
        pulse(3, 0);
        apb(1'b1, 8'h00, 32'h0);
        pulse(4, 0);
        rd(8'h08, 8'h01);
        $display("flag sources done");
        apb(1'b1, 8'h10, 32'h01);
        apb(1'b1, 8'h00, 32'h80);
        wait_for(0, 1'b0);
        apb(1'b1, 8'h00, 32'hC0);
        wait_for(0, 1'b1);
        chk({19'h0, pcv}, 32'h4);
        chk({31'h0, push}, 32'h1);
        rd(8'h00, 8'h40);
        apb(1'b1, 8'h08, 32'h0);
        pulse(1, 0);
        rd(8'h00, 8'hC0);
        wait_for(0, 1'b0);
        apb(1'b1, 8'h00, 32'hE0);
        pulse(0, 0);
        pulse(2, 0);
        wait_for(0, 1'b0);
        rd(8'h00, 8'h64);
        pulse(1, 0);
        wait_for(0, 1'b1);
        apb(1'b1, 8'h00, 32'h0);
        $display("service done");
        apb(1'b1, 8'h00, 32'h10);
        slp <= 1'b1;
        pin <= 1'b0;
        wait_for(1, 1'b1);
        rd(8'h20, 8'h10);
        apb(1'b1, 8'h00, 32'h0);
        pulse(5, 4'h1);
        slp <= 1'b0;
        rd(8'h20, 8'h00);
        rd(8'h24, 8'h04);
        apb(1'b1, 8'h00, 32'h80);
        pulse(5, 4'h4);
        rd(8'h00, 8'h00);
        rd(8'h20, 8'h00);
        pulse(5, 4'h2);
        pulse(5, 4'h8);
        rd(8'h20, 8'h18);
        rd(8'h24, 8'h04);
        $display("wake and reset causes done");
        wrap_up();
    end
endmodule
`default_nettype wire
